// [asrx_defs.vh]
// Register map, field positions, reset values and sampling counts
`ifndef ASRX_DEFS_VH
`define ASRX_DEFS_VH

`define ASRX_OFF_CTRL1 8'h00
`define ASRX_OFF_CTRL2 8'h04
`define ASRX_OFF_STAT1 8'h08
`define ASRX_OFF_STAT2 8'h0c
`define ASRX_OFF_CTRL3 8'h10
`define ASRX_OFF_DATA  8'h14
`define ASRX_OFF_BAUD  8'h18

`define ASRX_C1_LOOP     7
`define ASRX_C1_SRC      5
`define ASRX_C1_NINE     4
`define ASRX_C1_WAKE     3
`define ASRX_C1_IDLETYPE 2
`define ASRX_C1_PAREN    1
`define ASRX_C1_PARODD   0
`define ASRX_C1_MASK     8'hbf

`define ASRX_C2_TXEIE  7
`define ASRX_C2_TXCIE  6
`define ASRX_C2_RXFIE  5
`define ASRX_C2_IDLEIE 4
`define ASRX_C2_TXEN   3
`define ASRX_C2_RXEN   2
`define ASRX_C2_SLEEP  1
`define ASRX_C2_MASK   8'hfe

`define ASRX_S2_BRKF    7
`define ASRX_S2_EDGEF   6
`define ASRX_S2_EDGEIE  5
`define ASRX_S2_BRKIE   4
`define ASRX_S2_IDLEOPT 3

`define ASRX_C3_TX9     6
`define ASRX_C3_SWDIR   5
`define ASRX_C3_OVRIE   3
`define ASRX_C3_NOISEIE 2
`define ASRX_C3_FRMIE   1
`define ASRX_C3_PARIE   0
`define ASRX_C3_MASK    8'h6f

`define ASRX_CTRL_RST  8'h00
`define ASRX_BAUD_RST  13'h001a

`define ASRX_RT_FIRST  5'h01
`define ASRX_RT_LAST   5'h10
`define ASRX_RT_S1     5'h03
`define ASRX_RT_S2     5'h05
`define ASRX_RT_S3     5'h07
`define ASRX_RT_V1     5'h08
`define ASRX_RT_V2     5'h09
`define ASRX_RT_V3     5'h0a
`define ASRX_FRAME8    4'ha
`define ASRX_FRAME9    4'hb
`define ASRX_HIST_HIGH 3'h7

`endif

// [asrx_top.v]
// Asynchronous serial port receiver with wakeup, transmitter and bus slave
//
// Overview of operation
// - Line sampled at sixteen ticks per bit, numbered sub-periods.
// - Falling edge is a low sample after three high samples.
// - Start accepted if two of sub-periods 3, 5, 7 are low.
// - Each bit decided by majority of sub-periods 8, 9, 10.
// - Any sample disagreeing with its bit sets noise on transfer.
// - A falling edge detected in frame outside sub-periods 8 to 10 re-aligns the sub-period counter.
// - Framing error on non-break character preloads three high samples.
// - While framing flag set, no character enters the receive buffer.
// - Sleep suppresses all receive flags, except input edge and idle with wake option.
// - Idle-line wake clears sleep after 10 or 11 idle bit times.
// - Waking idle sets idle only with the idle wake option set.
// - Idle type selects counting after start bit or after stop.
// - Address-mark wake: msb one clears sleep, character is received.
// - Status read then data read clears receive-full flag.
// - Idle clears likewise, rearmed only by a new full character.
// - Error flags set with receive-full, never on overrun.
// - Full buffer on completion sets overrun, drops the character.
// - Enabled receiver edge sets input edge flag; write one clears.
// - Three maskable requests: transmit, receive, error.
// - Ninth transmit bit copied with data; ninth receive bit readable.
// - Deep stop loses registers; light stop keeps edge wake only.
// - Loop mode selects internal loopback or single-wire direction.
// - Frame is low start, eight or nine data lsb first, high stop.
// - At the stop-bit decision (sub-period 10), character moves to buffer if not full.
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "asrx_defs.vh"

module asrx_top (
  input  wire        clk,
  input  wire        reset,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire [1:0]  stopMode,
  input  wire        rxdPin,
  input  wire        txdPinIn,
  output wire        txdPinOut,
  output wire        txdPinOe_n,
  output wire        txIrq,
  output wire        rxIrq,
  output wire        errIrq,
  output wire        wakeReq
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_START = 2'd1;
  localparam ST_FRAME = 2'd2;

  function maj3;
    input a, b, c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  function agree3;
    input a, b, c;
    begin
      agree3 = (a == b) && (b == c);
    end
  endfunction

  reg        ack_q;
  reg [31:0] datO_q;
  reg [7:0]  ctrl1_q;
  reg [7:0]  ctrl2_q;
  reg [7:0]  ctrl3_q;
  reg [2:0]  stat2w_q;
  reg [12:0] baudDiv_q;
  reg [12:0] baudCnt_q;
  reg        rxdS1_q;
  reg        rxdS2_q;
  reg        txpS1_q;
  reg        txpS2_q;
  reg        lineP_q;
  reg [2:0]  hist_q;
  reg [1:0]  rxSt_q;
  reg [4:0]  rt_q;
  reg [3:0]  bitIdx_q;
  reg        va_q;
  reg        vb_q;
  reg        noise_q;
  reg [8:0]  shift_q;
  reg [8:0]  idleCnt_q;
  reg [8:0]  rxBuf_q;
  reg        rxFullFlag_q;
  reg        idleFlag_q;
  reg        overrunFlag_q;
  reg        noiseFlag_q;
  reg        framingErrorFlag_q;
  reg        parityErrorFlag_q;
  reg        breakDetectFlag_q;
  reg        inputEdgeFlag_q;
  reg        idleArm_q;
  reg [5:0]  rdArm_q;
  reg        txEmptyFlag_q;
  reg        txCompleteFlag_q;
  reg [7:0]  txBuf_q;
  reg        txBusy_q;
  reg [3:0]  txRt_q;
  reg [3:0]  txCnt_q;
  reg [10:0] txSh_q;
  reg        txOut_q;
  reg        txdPinOut_q;
  reg        txdPinOe_n_q;
  reg        txIrq_q;
  reg        rxIrq_q;
  reg        errIrq_q;
  reg        wakeReq_q;
  reg [7:0]  rdMux;

  // Stop handling: deep stop acts as reset, light stop freezes all but edge
  wire run  = (stopMode == 2'b00);
  wire deep = stopMode[1];
  wire lite = (stopMode == 2'b01);

  wire access = wb_cyc_i & wb_stb_i & ~ack_q & run;
  wire wrEn   = access & wb_we_i & wb_sel_i[0];
  wire rdEn   = access & ~wb_we_i;
  wire [7:0] wd = wb_dat_i[7:0];
  wire statRd = rdEn & (wb_adr_i == `ASRX_OFF_STAT1);
  wire dataRd = rdEn & (wb_adr_i == `ASRX_OFF_DATA);
  wire dataWr = wrEn & (wb_adr_i == `ASRX_OFF_DATA);
  wire s2Wr   = wrEn & (wb_adr_i == `ASRX_OFF_STAT2);

  wire nine    = ctrl1_q[`ASRX_C1_NINE];
  wire loopEn  = ctrl1_q[`ASRX_C1_LOOP];
  wire srcSel  = ctrl1_q[`ASRX_C1_SRC];
  wire swDir   = ctrl3_q[`ASRX_C3_SWDIR];
  wire rxOn    = ctrl2_q[`ASRX_C2_RXEN];
  wire sleep   = ctrl2_q[`ASRX_C2_SLEEP];
  wire idleOpt = stat2w_q[0];
  wire parOdd  = ctrl1_q[`ASRX_C1_PARODD];
  wire parEn   = ctrl1_q[`ASRX_C1_PAREN];
  wire [3:0] frameLen = nine ? `ASRX_FRAME9 : `ASRX_FRAME8;
  wire [3:0] nBits = frameLen - 4'd2;

  // receiver source: pin, internal loopback or shared transmit pin
  wire lineNow = ~loopEn ? rxdS2_q :
                 (srcSel & ~swDir) ? txpS2_q : txOut_q;

  // sixteen ticks per bit from the bus clock
  wire tick = run & (baudCnt_q == 13'd0) & (baudDiv_q != 13'd0);

  // falling edge after three high samples
  wire fallEdge = tick & rxOn & (hist_q == `ASRX_HIST_HIGH) & ~lineNow;
  wire inFrame  = (rxSt_q == ST_FRAME);
  wire vote     = maj3(va_q, vb_q, lineNow);
  wire decide   = tick & inFrame & (rt_q == `ASRX_RT_V3);
  wire isStop   = (bitIdx_q == frameLen - 4'd1);
  wire isMsb    = (bitIdx_q == nBits);
  // start disagrees if any vote sample is high, others by agreement
  wire noiseNow = decide & ((bitIdx_q == 4'd0) ?
                  (va_q | vb_q | lineNow) : ~agree3(va_q, vb_q, lineNow));
  wire charDone = decide & isStop;
  wire [8:0] rxData = nine ? shift_q : {1'b0, shift_q[8:1]};
  wire frmErr = ~vote;
  wire brkChar = frmErr & (rxData == 9'd0);
  wire parBad = parEn & ((^rxData) ^ parOdd);

  // address mark clears sleep at the msb, before the stop bit
  wire addrWake = decide & isMsb & vote & sleep & ctrl1_q[`ASRX_C1_WAKE];

  // idle type holds the count during the whole character
  wire [8:0] idleThr = {1'b0, frameLen, 4'h0};
  wire idleHold = ~lineNow |
                  (ctrl1_q[`ASRX_C1_IDLETYPE] & (rxSt_q != ST_IDLE));
  wire idleHit = tick & rxOn & ~idleHold & (idleCnt_q == idleThr - 9'd1);
  wire idleWake = idleHit & sleep & ~ctrl1_q[`ASRX_C1_WAKE];

  // sleep blocks flags; framing flag blocks transfer
  wire xferOk  = charDone & ~sleep & ~framingErrorFlag_q;
  // load when buffer empty, overrun otherwise
  wire loadBuf = xferOk & ~rxFullFlag_q;
  wire ovrSet  = xferOk & rxFullFlag_q;
  // idle flag needs arming and sleep permission
  wire idleSet = idleHit & idleArm_q & (~sleep | idleOpt);
  wire [5:0] clrSeq = dataRd ? rdArm_q : 6'b0;
  // edge detect while receiver enabled, also in light stop
  wire inEdge = rxOn & lineP_q & ~lineNow & (run | lite);

  wire [7:0] txB7 = {(parEn & ~nine) ? ((^txBuf_q[6:0]) ^ parOdd)
                     : txBuf_q[7], txBuf_q[6:0]};
  wire txB8 = parEn ? ((^txBuf_q) ^ parOdd) : ctrl3_q[`ASRX_C3_TX9];
  // ninth bit copied with the data into the shifter
  wire [10:0] txFrame = nine ? {1'b1, txB8, txBuf_q, 1'b0}
                             : {2'b11, txB7, 1'b0};

  assign wb_dat_o   = datO_q;
  assign wb_ack_o   = ack_q;
  assign txdPinOut  = txdPinOut_q;
  assign txdPinOe_n = txdPinOe_n_q;
  assign txIrq      = txIrq_q;
  assign rxIrq      = rxIrq_q;
  assign errIrq     = errIrq_q;
  assign wakeReq    = wakeReq_q;

  always @* begin
    case (wb_adr_i)
      `ASRX_OFF_CTRL1: rdMux = ctrl1_q;
      `ASRX_OFF_CTRL2: rdMux = ctrl2_q;
      `ASRX_OFF_STAT1: rdMux = {txEmptyFlag_q, txCompleteFlag_q,
                                rxFullFlag_q, idleFlag_q, overrunFlag_q,
                                noiseFlag_q, framingErrorFlag_q,
                                parityErrorFlag_q};
      `ASRX_OFF_STAT2: rdMux = {breakDetectFlag_q, inputEdgeFlag_q,
                                stat2w_q, 2'b00, rxSt_q != ST_IDLE};
      `ASRX_OFF_CTRL3: rdMux = {rxBuf_q[8], ctrl3_q[6:0]};
      `ASRX_OFF_DATA:  rdMux = rxBuf_q[7:0];
      default:         rdMux = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    rxdS1_q <= rxdPin;
    rxdS2_q <= rxdS1_q;
    txpS1_q <= txdPinIn;
    txpS2_q <= txpS1_q;
  end

  always @(posedge clk) begin
    if (reset | deep) begin
      // deep stop loses all register contents
      ack_q <= 1'b0;
      datO_q <= 32'h0;
      ctrl1_q <= `ASRX_CTRL_RST;
      ctrl2_q <= `ASRX_CTRL_RST;
      ctrl3_q <= `ASRX_CTRL_RST;
      stat2w_q <= 3'h0;
      baudDiv_q <= `ASRX_BAUD_RST;
      baudCnt_q <= 13'h0;
      lineP_q <= 1'b1;
      hist_q <= 3'h0;
      rxSt_q <= ST_IDLE;
      rt_q <= `ASRX_RT_FIRST;
      bitIdx_q <= 4'h0;
      va_q <= 1'b0;
      vb_q <= 1'b0;
      noise_q <= 1'b0;
      shift_q <= 9'h0;
      idleCnt_q <= 9'h0;
      rxBuf_q <= 9'h0;
      rxFullFlag_q <= 1'b0;
      idleFlag_q <= 1'b0;
      overrunFlag_q <= 1'b0;
      noiseFlag_q <= 1'b0;
      framingErrorFlag_q <= 1'b0;
      parityErrorFlag_q <= 1'b0;
      breakDetectFlag_q <= 1'b0;
      inputEdgeFlag_q <= 1'b0;
      idleArm_q <= 1'b0;
      rdArm_q <= 6'h0;
      txEmptyFlag_q <= 1'b1;
      txCompleteFlag_q <= 1'b1;
      txBuf_q <= 8'h0;
      txBusy_q <= 1'b0;
      txRt_q <= 4'h0;
      txCnt_q <= 4'h0;
      txSh_q <= 11'h7ff;
      txOut_q <= 1'b1;
      txdPinOut_q <= 1'b1;
      txdPinOe_n_q <= 1'b0;
      txIrq_q <= 1'b0;
      rxIrq_q <= 1'b0;
      errIrq_q <= 1'b0;
      wakeReq_q <= 1'b0;
    end else begin
      lineP_q <= lineNow;
      inputEdgeFlag_q <= (inputEdgeFlag_q &
                          ~(s2Wr & wd[`ASRX_S2_EDGEF])) | inEdge;
      wakeReq_q <= lite & inEdge & stat2w_q[2];
      if (run) begin
        ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
        if (rdEn)
          datO_q <= {24'h0, rdMux};
        if (wrEn) begin
          case (wb_adr_i)
            `ASRX_OFF_CTRL1: ctrl1_q <= wd & `ASRX_C1_MASK;
            `ASRX_OFF_CTRL3: ctrl3_q <= wd & `ASRX_C3_MASK;
            `ASRX_OFF_STAT2: stat2w_q <= wd[5:3];
            `ASRX_OFF_BAUD:  baudDiv_q <= wb_dat_i[12:0];
            `ASRX_OFF_DATA:  txBuf_q <= wd;
            default: ;
          endcase
        end
        // hardware wake clears sleep; a software write in the same cycle wins
        if (wrEn && wb_adr_i == `ASRX_OFF_CTRL2)
          ctrl2_q <= wd & `ASRX_C2_MASK;
        else if (idleWake | addrWake)
          ctrl2_q[`ASRX_C2_SLEEP] <= 1'b0;
        baudCnt_q <= (baudCnt_q == 13'd0) ? baudDiv_q - 13'd1
                                          : baudCnt_q - 13'd1;
        if (baudDiv_q == 13'd0)
          baudCnt_q <= 13'd0;

        // status read arms the clear, data read completes it
        if (statRd)
          rdArm_q <= {rxFullFlag_q, idleFlag_q, overrunFlag_q,
                      noiseFlag_q, framingErrorFlag_q, parityErrorFlag_q};
        else if (dataRd)
          rdArm_q <= 6'h0;
        rxFullFlag_q <= (rxFullFlag_q & ~clrSeq[5]) | loadBuf;
        // idle clears by sequence and rearms on a new character
        idleFlag_q <= (idleFlag_q & ~clrSeq[4]) | idleSet;
        idleArm_q <= (idleArm_q & ~idleSet) | loadBuf;
        // overrun set, character and its errors dropped
        overrunFlag_q <= (overrunFlag_q & ~clrSeq[3]) | ovrSet;
        // errors set together with receive-full only
        noiseFlag_q <= (noiseFlag_q & ~clrSeq[2]) |
                       (loadBuf & (noise_q | noiseNow));
        framingErrorFlag_q <= (framingErrorFlag_q & ~clrSeq[1]) |
                              (loadBuf & frmErr);
        parityErrorFlag_q <= (parityErrorFlag_q & ~clrSeq[0]) |
                             (loadBuf & parBad);
        breakDetectFlag_q <= (breakDetectFlag_q &
                              ~(s2Wr & wd[`ASRX_S2_BRKF])) |
                             (charDone & ~sleep & brkChar);
        if (loadBuf)
          rxBuf_q <= rxData;

        if (tick) begin
          hist_q <= {hist_q[1:0], lineNow};
          if (idleHold)
            idleCnt_q <= 9'h0;
          else if (idleCnt_q != idleThr)
            idleCnt_q <= idleCnt_q + 9'd1;
          if (rt_q == `ASRX_RT_LAST)
            rt_q <= `ASRX_RT_FIRST;
          else
            rt_q <= rt_q + 5'd1;
          if (rt_q == `ASRX_RT_S1 || rt_q == `ASRX_RT_V1)
            va_q <= lineNow;
          if (rt_q == `ASRX_RT_S2 || rt_q == `ASRX_RT_V2)
            vb_q <= lineNow;
          case (rxSt_q)
            ST_IDLE: begin
              if (fallEdge) begin
                rxSt_q <= ST_START;
                rt_q <= `ASRX_RT_FIRST + 5'd1;
                bitIdx_q <= 4'h0;
                noise_q <= 1'b0;
              end
            end
            ST_START: begin
              // two of three low samples accept the start bit
              if (rt_q == `ASRX_RT_S3) begin
                rxSt_q <= vote ? ST_IDLE : ST_FRAME;
                noise_q <= ~agree3(va_q, vb_q, lineNow);
              end
            end
            ST_FRAME: begin
              if (fallEdge && (rt_q > `ASRX_RT_V3 || rt_q < `ASRX_RT_V1))
                rt_q <= `ASRX_RT_FIRST + 5'd1;
              // majority decides each bit, lsb first
              if (decide) begin
                noise_q <= noise_q | noiseNow;
                bitIdx_q <= bitIdx_q + 4'd1;
                if (bitIdx_q != 4'd0 && !isStop)
                  shift_q <= {vote, shift_q[8:1]};
                if (isStop) begin
                  rxSt_q <= ST_IDLE;
                  // non-break framing error preloads edge history
                  if (frmErr & ~brkChar)
                    hist_q <= `ASRX_HIST_HIGH;
                end
              end
            end
            default: rxSt_q <= ST_IDLE;
          endcase
          if (!rxOn)
            rxSt_q <= ST_IDLE;

          if (!txBusy_q) begin
            if (ctrl2_q[`ASRX_C2_TXEN] && !txEmptyFlag_q) begin
              txSh_q <= txFrame;
              txOut_q <= txFrame[0];
              txBusy_q <= 1'b1;
              txRt_q <= 4'h0;
              txCnt_q <= frameLen;
              txEmptyFlag_q <= 1'b1;
            end else
              txOut_q <= 1'b1;
          end else begin
            txRt_q <= txRt_q + 4'd1;
            if (txRt_q == 4'hf) begin
              txSh_q <= {1'b1, txSh_q[10:1]};
              txOut_q <= txSh_q[1];
              txCnt_q <= txCnt_q - 4'd1;
              if (txCnt_q == 4'd1) begin
                txBusy_q <= 1'b0;
                txOut_q <= 1'b1;
              end
            end
          end
        end
        if (dataWr) begin
          txEmptyFlag_q <= 1'b0;
          txCompleteFlag_q <= 1'b0;
        end
        if (tick && txBusy_q && txRt_q == 4'hf && txCnt_q == 4'd1 &&
            txEmptyFlag_q)
          txCompleteFlag_q <= 1'b1;

        // pin driven except single-wire receive direction
        txdPinOut_q <= txOut_q;
        txdPinOe_n_q <= loopEn & srcSel & ~swDir;
        txIrq_q <= (ctrl2_q[`ASRX_C2_TXEIE] & txEmptyFlag_q) |
                   (ctrl2_q[`ASRX_C2_TXCIE] & txCompleteFlag_q);
        rxIrq_q <= (ctrl2_q[`ASRX_C2_RXFIE] & rxFullFlag_q) |
                   (ctrl2_q[`ASRX_C2_IDLEIE] & idleFlag_q) |
                   (stat2w_q[2] & inputEdgeFlag_q) |
                   (stat2w_q[1] & breakDetectFlag_q);
        errIrq_q <= (ctrl3_q[`ASRX_C3_OVRIE] & overrunFlag_q) |
                    (ctrl3_q[`ASRX_C3_NOISEIE] & noiseFlag_q) |
                    (ctrl3_q[`ASRX_C3_FRMIE] & framingErrorFlag_q) |
                    (ctrl3_q[`ASRX_C3_PARIE] & parityErrorFlag_q);
      end
    end
  end

endmodule

// [asrx_assertions.sv]
// Port checker for the serial receiver block
`timescale 1ns/1ps
module asrx_assertions (
  input logic       clk,
  input logic       reset,
  input logic       wb_cyc_i,
  input logic       wb_stb_i,
  input logic       wb_ack_o,
  input logic [1:0] stopMode,
  input logic       txdPinOut,
  input logic       txdPinOe_n,
  input logic       txIrq,
  input logic       rxIrq,
  input logic       errIrq,
  input logic       wakeReq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o && stopMode == 2'b00 |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("request not answered in one cycle");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && stopMode == 2'b00);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  property p_rst_pin;
    $past(reset) |-> txdPinOut && !txdPinOe_n;
  endproperty
  a_rst_pin: assert property (p_rst_pin)
    else $error("transmit pin not idle high after reset");
  property p_rst_irq;
    $past(reset) |-> !txIrq && !rxIrq && !errIrq && !wakeReq;
  endproperty
  a_rst_irq: assert property (p_rst_irq)
    else $error("request active after reset");
  property p_wake_pulse;
    wakeReq |=> !wakeReq;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake request longer than one cycle");
  property p_wake_stop;
    wakeReq |-> $past(stopMode) == 2'b01;
  endproperty
  a_wake_stop: assert property (p_wake_stop)
    else $error("wake request outside light stop");
  property p_stop_no_ack;
    stopMode != 2'b00 |=> !wb_ack_o;
  endproperty
  a_stop_no_ack: assert property (p_stop_no_ack)
    else $error("access answered during stop");
  property p_deep_clear;
    stopMode[1] [*2] |-> !txIrq && !rxIrq && !errIrq && !wakeReq && txdPinOut;
  endproperty
  a_deep_clear: assert property (p_deep_clear)
    else $error("deep stop did not clear outputs");
  c_wake: cover property (wakeReq);
  c_err: cover property (errIrq);
  c_rx: cover property (rxIrq);
  c_deep: cover property (stopMode[1]);
endmodule

bind asrx_top asrx_assertions i_asrx_assertions (
  .clk        (clk),
  .reset      (reset),
  .wb_cyc_i   (wb_cyc_i),
  .wb_stb_i   (wb_stb_i),
  .wb_ack_o   (wb_ack_o),
  .stopMode   (stopMode),
  .txdPinOut  (txdPinOut),
  .txdPinOe_n (txdPinOe_n),
  .txIrq      (txIrq),
  .rxIrq      (rxIrq),
  .errIrq     (errIrq),
  .wakeReq    (wakeReq)
);

// [asrx_remote_dev.sv]
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module asrx_remote_dev #(
  parameter int BIT_CLKS = 16
) (
  input  logic clk,
  output logic line
);
  initial line = 1'b1;
  // Start low, data lsb first, stop
  // Sixteen ticks per bit, glitch at tick 9
  task automatic send(input logic [8:0] d, input bit nine, input bit stp,
                      input int g);
    logic [10:0] f;
    f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      for (int k = 1; k <= BIT_CLKS; k++) begin
        @(posedge clk);
        line <= f[i] ^ (i == g && k == 9);
      end
    end
    @(posedge clk);
    line <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
endmodule

// [asrx_top_tb.sv]
// Self-checking bench for the serial receiver block
`timescale 1ns/1ps
`include "asrx_defs.vh"
module asrx_top_tb;
  logic        clk;
  logic        reset;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [31:0] wbDatW;
  wire  [31:0] wbDatR;
  wire         wbAck;
  logic [1:0]  stopMode;
  wire         rxLine;
  wire         txdPinIn;
  wire         txdPinOut;
  wire         txdPinOe_n;
  wire         txIrq;
  wire         rxIrq;
  wire         errIrq;
  wire         wakeReq;
  logic        wakeSeen;
  int          fail_count;
  int          check_count;

  assign txdPinIn = txdPinOe_n ? 1'b1 : txdPinOut;

  asrx_top i_asrx_top (
    .clk(clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDatW),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .stopMode(stopMode),
    .rxdPin(rxLine), .txdPinIn(txdPinIn), .txdPinOut(txdPinOut),
    .txdPinOe_n(txdPinOe_n), .txIrq(txIrq), .rxIrq(rxIrq),
    .errIrq(errIrq), .wakeReq(wakeReq));
  asrx_remote_dev i_asrx_remote_dev (.clk(clk), .line(rxLine));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (wakeReq) wakeSeen <= 1'b1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= {24'h0, d};
    @(posedge clk);
    while (wbAck !== 1'b1) @(posedge clk);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(q, e);
  endtask
  task automatic tx(input logic [8:0] d, input bit n, input bit s, input int g);
    i_asrx_remote_dev.send(d, n, s, g);
  endtask
  task automatic done(input string n);
    $display("test %s done", n);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial begin
    int i;
    reset = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatW = 32'h0;
    stopMode = 2'b00;
    wakeSeen = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(`ASRX_OFF_STAT1, 32'hc0);
    rd(`ASRX_OFF_CTRL2, 32'h00);
    rd(`ASRX_OFF_BAUD, 32'h00);
    rd(8'h1c, 32'h00);
    wr(`ASRX_OFF_BAUD, 8'h01);
    wr(`ASRX_OFF_CTRL2, 8'h24);
    done("reset");
    repeat (40) @(posedge clk);
    tx(9'h0a5, 0, 1, -1);
    chk(rxIrq, 1'b1);
    rd(`ASRX_OFF_STAT1, 32'he0);
    rd(`ASRX_OFF_DATA, 32'ha5);
    rd(`ASRX_OFF_STAT1, 32'hc0);
    rd(`ASRX_OFF_STAT2, 32'h40);
    wr(`ASRX_OFF_STAT2, 8'h40);
    rd(`ASRX_OFF_STAT2, 32'h00);
    done("frame");
    tx(9'h03c, 0, 1, 4);
    rd(`ASRX_OFF_STAT1, 32'he4);
    rd(`ASRX_OFF_DATA, 32'h3c);
    tx(9'h0a1, 0, 1, -1);
    tx(9'h0b2, 0, 1, -1);
    rd(`ASRX_OFF_STAT1, 32'he8);
    rd(`ASRX_OFF_DATA, 32'ha1);
    rd(`ASRX_OFF_STAT1, 32'hc0);
    done("noise overrun");
    wr(`ASRX_OFF_CTRL3, 8'h02);
    tx(9'h055, 0, 0, -1);
    chk(errIrq, 1'b1);
    rd(`ASRX_OFF_STAT1, 32'he2);
    rd(`ASRX_OFF_DATA, 32'h55);
    wr(`ASRX_OFF_CTRL3, 8'h00);
    repeat (200) @(posedge clk);
    rd(`ASRX_OFF_STAT1, 32'hf4);
    rd(`ASRX_OFF_DATA, 32'hff);
    done("framing");
    wr(`ASRX_OFF_CTRL1, 8'h18);
    wr(`ASRX_OFF_CTRL2, 8'h06);
    tx(9'h011, 1, 1, -1);
    rd(`ASRX_OFF_STAT1, 32'hc0);
    tx(9'h122, 1, 1, -1);
    rd(`ASRX_OFF_CTRL2, 32'h04);
    rd(`ASRX_OFF_STAT1, 32'he0);
    rd(`ASRX_OFF_DATA, 32'h22);
    rd(`ASRX_OFF_CTRL3, 32'h80);
    wr(`ASRX_OFF_CTRL1, 8'h00);
    wr(`ASRX_OFF_CTRL2, 8'h06);
    tx(9'h0f0, 0, 1, -1);
    repeat (12 * 16) @(posedge clk);
    rd(`ASRX_OFF_CTRL2, 32'h04);
    rd(`ASRX_OFF_STAT1, 32'hc0);
    done("wakeup");
    wr(`ASRX_OFF_CTRL1, 8'h80);
    wr(`ASRX_OFF_CTRL2, 8'h6c);
    wr(`ASRX_OFF_DATA, 8'h5a);
    for (i = 0; i < 1000 && rxIrq !== 1'b1; i++) @(posedge clk);
    rd(`ASRX_OFF_DATA, 32'h5a);
    repeat (4) @(posedge clk);
    chk(txIrq, 1'b1);
    wr(`ASRX_OFF_CTRL1, 8'ha0);
    @(posedge clk);
    chk(txdPinOe_n, 1'b1);
    done("loop");
    wr(`ASRX_OFF_CTRL1, 8'h00);
    wr(`ASRX_OFF_STAT2, 8'h20);
    stopMode <= 2'b01;
    tx(9'h0ff, 0, 1, -1);
    stopMode <= 2'b00;
    chk(wakeSeen, 1'b1);
    rd(`ASRX_OFF_CTRL2, 32'h6c);
    stopMode <= 2'b10;
    repeat (3) @(posedge clk);
    stopMode <= 2'b00;
    rd(`ASRX_OFF_CTRL2, 32'h00);
    rd(`ASRX_OFF_STAT1, 32'hc0);
    done("stop");
    end_sim();
  end
endmodule
